// File: ccfd_pkg.sv
// Shared constants and carriers for the condition and flag block
package ccfd_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [7:0] IDX_IMASK = 8'hfb; // interrupt_mask
  localparam logic [7:0] IDX_FLAGS = 8'hfc; // status_flags
  localparam logic [7:0] IDX_WBP   = 8'hfd; // working_bank_pointer
  localparam logic [7:0] IDX_CSEL  = 8'h00; // Software condition select
  localparam logic [7:0] IDX_CSTAT = 8'h01; // Block status

  // Reset values
  localparam logic [7:0] RST_IMASK = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_WBP   = 8'h00;
  localparam logic [3:0] RST_CSEL  = 4'h0;

  // Flags sit in register bits 7..2, low two bits read zero
  localparam int FLAG_LSB = 2;
  // Positions inside the six-bit flag vector
  localparam int F_C = 5;
  localparam int F_Z = 4;
  localparam int F_S = 3;
  localparam int F_V = 2;
  localparam int F_D = 1;
  localparam int F_H = 0;

  // Block status bit positions
  localparam int ST_COND = 0; // Selected condition currently true
  localparam int ST_PREJ = 1; // Sticky pair-mode reject, write one to clear

  // Condition codes
  localparam logic [3:0] CC_NEVER              = 4'h0;
  localparam logic [3:0] CC_LT                 = 4'h1;
  localparam logic [3:0] CC_LE                 = 4'h2;
  localparam logic [3:0] CC_UNSIGNED_AT_MOST   = 4'h3;
  localparam logic [3:0] CC_OV                 = 4'h4;
  localparam logic [3:0] CC_MI                 = 4'h5;
  localparam logic [3:0] CC_ZERO               = 4'h6;
  localparam logic [3:0] CC_CARRY              = 4'h7;
  localparam logic [3:0] CC_ALWAYS             = 4'h8;
  localparam logic [3:0] CC_GE                 = 4'h9;
  localparam logic [3:0] CC_GT                 = 4'ha;
  localparam logic [3:0] CC_UNSIGNED_ABOVE     = 4'hb;
  localparam logic [3:0] CC_NO_SIGNED_OVERFLOW = 4'hc;
  localparam logic [3:0] CC_PL                 = 4'hd;
  localparam logic [3:0] CC_NZ                 = 4'he;
  localparam logic [3:0] CC_NC                 = 4'hf;

  // Opcode high nibbles of the arithmetic pair
  localparam logic [3:0] OPN_ADD = 4'h0;
  localparam logic [3:0] OPN_ADC = 4'h1;
  // High nibble that marks a working-register pair address
  localparam logic [3:0] WORK_NIB = 4'he;
  // Carry out of the low nibble
  localparam logic [4:0] HALF_LIM = 5'h0f;

  // Per-flag effect class
  typedef enum logic [2:0] {FX_CLEAR, FX_SET, FX_CALC, FX_KEEP, FX_UNDEF} ccfd_fx_type;

  // Operand addressing mode under check
  typedef enum logic [1:0] {AM_OTHER, AM_PAIR_ANY, AM_PAIR_WORK} ccfd_amode_type;

  // One instruction step presented by the core
  typedef struct packed {
    logic           valid;
    logic [7:0]     opcode;
    logic [7:0]     dst;
    logic [7:0]     src;
    logic [3:0]     cc;
    ccfd_amode_type amode;
    logic [7:0]     pair_addr;
    ccfd_fx_type [5:0] fx;
    logic [5:0]     calc;
  } ccfd_exec_type;

  // Registered answer to one step
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       wr_dst;
    logic       cond_met;
    logic       pair_ok;
  } ccfd_result_type;
endpackage : ccfd_pkg

// File: ccfd_top.sv
`timescale 1ns/1ns
module ccfd_top (
  // Clock, reset and enable
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     ce_i,
  // Wishbone slave
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [9:2]               wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  // Core step port
  input  wire ccfd_pkg::ccfd_exec_type  exec_i,
  output ccfd_pkg::ccfd_result_type     result_o,
  // Register contents seen by the core
  output logic      [7:0]               imask_o,
  output logic      [7:0]               wbp_o,
  output logic      [5:0]               flags_o
);

  // Stored state
  logic [5:0] flag_q;    // C Z S V D H
  logic [7:0] imask_q;   // interrupt_mask
  logic [7:0] wbp_q;     // working_bank_pointer
  logic [3:0] csel_q;    // Software condition select
  logic       prej_q;    // Sticky pair reject

  // Bus decode
  logic       bus_req;   // New access this cycle
  logic       bus_wr;    // Write with low lane enabled
  logic       wr_flags;
  logic       wr_imask;
  logic       wr_wbp;
  logic       wr_csel;
  logic       wr_cstat;

  // Step decode
  logic       is_arith;  // Add or add-with-carry
  logic       cin;       // Carry into the adder
  logic [8:0] sum9;      // Sum with carry out
  logic [4:0] half5;     // Low nibble sum
  logic [5:0] arith_f;   // Flags from the adder
  logic [5:0] next_flag; // Flags after the step
  logic       cond_now;  // Step condition, combinational
  logic       sw_cond;   // Software-selected condition
  logic       pair_ok;   // Addressing mode accepted

  // Evaluate a condition code against a flag vector
  function automatic logic cond_eval(input logic [3:0] cc, input logic [5:0] f);
    logic sv;
    sv = f[ccfd_pkg::F_S] ^ f[ccfd_pkg::F_V];
    case (cc)
      ccfd_pkg::CC_NEVER:              cond_eval = 1'b0;
      ccfd_pkg::CC_ALWAYS:             cond_eval = 1'b1;
      ccfd_pkg::CC_CARRY:              cond_eval = f[ccfd_pkg::F_C];
      ccfd_pkg::CC_NC:                 cond_eval = !f[ccfd_pkg::F_C];
      ccfd_pkg::CC_ZERO:               cond_eval = f[ccfd_pkg::F_Z];
      ccfd_pkg::CC_NZ:                 cond_eval = !f[ccfd_pkg::F_Z];
      ccfd_pkg::CC_MI:                 cond_eval = f[ccfd_pkg::F_S];
      ccfd_pkg::CC_PL:                 cond_eval = !f[ccfd_pkg::F_S];
      ccfd_pkg::CC_OV:                 cond_eval = f[ccfd_pkg::F_V];
      ccfd_pkg::CC_NO_SIGNED_OVERFLOW: cond_eval = !f[ccfd_pkg::F_V];
      ccfd_pkg::CC_GE:                 cond_eval = !sv;
      ccfd_pkg::CC_LT:                 cond_eval = sv;
      ccfd_pkg::CC_GT:                 cond_eval = !(f[ccfd_pkg::F_Z] | sv);
      ccfd_pkg::CC_LE:                 cond_eval = f[ccfd_pkg::F_Z] | sv;
      ccfd_pkg::CC_UNSIGNED_ABOVE:
        cond_eval = !f[ccfd_pkg::F_C] && !f[ccfd_pkg::F_Z];
      default:
        cond_eval = f[ccfd_pkg::F_C] | f[ccfd_pkg::F_Z];
    endcase
  endfunction : cond_eval

  // Apply one effect class to one flag
  function automatic logic apply_fx(input ccfd_pkg::ccfd_fx_type fx, input logic old,
                                    input logic calc);
    case (fx)
      ccfd_pkg::FX_CLEAR: apply_fx = 1'b0;
      ccfd_pkg::FX_SET:   apply_fx = 1'b1;
      ccfd_pkg::FX_CALC:  apply_fx = calc;
      // Undefined flags are left as they are, which software may not rely on
      default:            apply_fx = old;
    endcase
  endfunction : apply_fx

  // Accept or refuse a pair address for the mode
  function automatic logic pair_mode_ok(input ccfd_pkg::ccfd_amode_type m,
                                        input logic [7:0] a);
    if (m == ccfd_pkg::AM_PAIR_WORK) begin
      pair_mode_ok = (a[7:4] == ccfd_pkg::WORK_NIB);
    end else begin
      pair_mode_ok = 1'b1;
    end
  endfunction : pair_mode_ok

  // Address decode; ack in flight blocks a second take of the same request
  always_comb begin
    bus_req  = ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o;
    bus_wr   = bus_req && wb_we_i && wb_sel_i[0];
    wr_flags = 1'b0;
    wr_imask = 1'b0;
    wr_wbp   = 1'b0;
    wr_csel  = 1'b0;
    wr_cstat = 1'b0;
    if (wb_adr_i == ccfd_pkg::IDX_FLAGS) begin
      wr_flags = bus_wr;
    end else if (wb_adr_i == ccfd_pkg::IDX_IMASK) begin
      wr_imask = bus_wr;
    end else if (wb_adr_i == ccfd_pkg::IDX_WBP) begin
      wr_wbp = bus_wr;
    end else if (wb_adr_i == ccfd_pkg::IDX_CSEL) begin
      wr_csel = bus_wr;
    end else if (wb_adr_i == ccfd_pkg::IDX_CSTAT) begin
      wr_cstat = bus_wr;
    end
  end

  // Adder for the arithmetic pair
  always_comb begin
    is_arith = (exec_i.opcode[7:4] == ccfd_pkg::OPN_ADD) ||
               (exec_i.opcode[7:4] == ccfd_pkg::OPN_ADC);
    cin      = (exec_i.opcode[7:4] == ccfd_pkg::OPN_ADC) && flag_q[ccfd_pkg::F_C];
    sum9     = {1'b0, exec_i.dst} + {1'b0, exec_i.src} + {8'h00, cin};
    half5    = {1'b0, exec_i.dst[3:0]} + {1'b0, exec_i.src[3:0]} + {4'h0, cin};
    arith_f[ccfd_pkg::F_C] = sum9[8];
    arith_f[ccfd_pkg::F_Z] = (sum9[7:0] == 8'h00);
    arith_f[ccfd_pkg::F_S] = sum9[7];
    arith_f[ccfd_pkg::F_V] = (exec_i.dst[7] == exec_i.src[7]) && (sum9[7] != exec_i.dst[7]);
    arith_f[ccfd_pkg::F_D] = 1'b0;
    arith_f[ccfd_pkg::F_H] = (half5 > ccfd_pkg::HALF_LIM);
  end

  // Flag next value: adder flags for the add pair, effect classes otherwise
  always_comb begin
    next_flag = flag_q;
    if (exec_i.valid && is_arith) begin
      next_flag = arith_f;
    end else if (exec_i.valid) begin
      for (int i = 0; i < 6; i++) begin
        next_flag[i] = apply_fx(exec_i.fx[i], flag_q[i], exec_i.calc[i]);
      end
    end
  end

  // Conditions read the stored flags with no register in between
  always_comb begin
    cond_now = cond_eval(exec_i.cc, flag_q);
    sw_cond  = cond_eval(csel_q, flag_q);
    pair_ok  = pair_mode_ok(exec_i.amode, exec_i.pair_addr);
  end

  // Flag register; a bus write wins over a step in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_q <= ccfd_pkg::RST_FLAGS[7:2];
    end else if (ce_i) begin
      if (wr_flags) begin
        flag_q <= wb_dat_i[7:2];
      end else begin
        flag_q <= next_flag;
      end
    end
  end

  // Mask and bank pointer registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      imask_q <= ccfd_pkg::RST_IMASK;
      wbp_q   <= ccfd_pkg::RST_WBP;
    end else if (ce_i) begin
      if (wr_imask) begin
        imask_q <= wb_dat_i[7:0];
      end
      if (wr_wbp) begin
        wbp_q <= wb_dat_i[7:0];
      end
    end
  end

  // Software condition select and sticky reject; a new reject beats the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      csel_q <= ccfd_pkg::RST_CSEL;
      prej_q <= 1'b0;
    end else if (ce_i) begin
      if (wr_csel) begin
        csel_q <= wb_dat_i[3:0];
      end
      if (exec_i.valid && !pair_ok) begin
        prej_q <= 1'b1;
      end else if (wr_cstat && wb_dat_i[ccfd_pkg::ST_PREJ]) begin
        prej_q <= 1'b0;
      end
    end
  end

  // Step answer, one cycle after the step is taken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_o <= '0;
    end else if (ce_i) begin
      result_o.valid    <= exec_i.valid;
      result_o.data     <= sum9[7:0];
      result_o.wr_dst   <= exec_i.valid && is_arith;
      result_o.cond_met <= cond_now;
      result_o.pair_ok  <= pair_ok;
    end
  end

  // Bus answer: ack one cycle after the request, unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else if (ce_i) begin
      wb_ack_o <= bus_req;
      wb_dat_o <= '0;
      if (wb_adr_i == ccfd_pkg::IDX_FLAGS) begin
        wb_dat_o[7:0] <= {flag_q, 2'b00};
      end else if (wb_adr_i == ccfd_pkg::IDX_IMASK) begin
        wb_dat_o[7:0] <= imask_q;
      end else if (wb_adr_i == ccfd_pkg::IDX_WBP) begin
        wb_dat_o[7:0] <= wbp_q;
      end else if (wb_adr_i == ccfd_pkg::IDX_CSEL) begin
        wb_dat_o[3:0] <= csel_q;
      end else if (wb_adr_i == ccfd_pkg::IDX_CSTAT) begin
        wb_dat_o[1:0] <= {prej_q, sw_cond};
      end
    end
  end

  // Register copies for the core
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      imask_o <= ccfd_pkg::RST_IMASK;
      wbp_o   <= ccfd_pkg::RST_WBP;
      flags_o <= ccfd_pkg::RST_FLAGS[7:2];
    end else if (ce_i) begin
      imask_o <= wr_imask ? wb_dat_i[7:0] : imask_q;
      wbp_o   <= wr_wbp ? wb_dat_i[7:0] : wbp_q;
      flags_o <= wr_flags ? wb_dat_i[7:2] : next_flag;
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // A step with a given condition code
  sequence s_step(logic [3:0] c);
    ce_i && exec_i.valid && exec_i.cc == c;
  endsequence

  // A bus access to a given index
  sequence s_acc(logic [7:0] a, logic w);
    bus_req && wb_we_i == w && wb_adr_i == a;
  endsequence

  AST_FLAG_READ: assert property (s_acc(ccfd_pkg::IDX_FLAGS, 1'b0) |=>
    wb_ack_o && wb_dat_o == {24'h000000, $past(flag_q), 2'b00})
    else $error("flag register read wrong");

  AST_MASK_WRITE: assert property (s_acc(ccfd_pkg::IDX_IMASK, 1'b1) ##0 wb_sel_i[0] |=>
    imask_q == $past(wb_dat_i[7:0]) ##1 imask_o == $past(wb_dat_i[7:0], 2))
    else $error("mask register write lost");

  AST_ALWAYS: assert property (s_step(ccfd_pkg::CC_ALWAYS) |=> result_o.cond_met)
    else $error("always code not true");

  AST_NEVER: assert property (s_step(ccfd_pkg::CC_NEVER) |=> !result_o.cond_met)
    else $error("never code true");

  AST_CARRY: assert property (s_step(ccfd_pkg::CC_CARRY) |=>
    result_o.cond_met == $past(flag_q[ccfd_pkg::F_C]))
    else $error("carry code wrong");

  AST_SIGNED: assert property (s_step(ccfd_pkg::CC_GT) |=>
    result_o.cond_met == !$past(flag_q[ccfd_pkg::F_Z] |
                                (flag_q[ccfd_pkg::F_S] ^ flag_q[ccfd_pkg::F_V])))
    else $error("signed greater code wrong");

  AST_UNSIGNED: assert property (s_step(ccfd_pkg::CC_UNSIGNED_AT_MOST) |=>
    result_o.cond_met == $past(flag_q[ccfd_pkg::F_C] | flag_q[ccfd_pkg::F_Z]))
    else $error("unsigned at most code wrong");

  AST_ADD_WB: assert property (ce_i && exec_i.valid && is_arith && !wr_flags |=>
    result_o.wr_dst && !flag_q[ccfd_pkg::F_D] &&
    result_o.data == $past(exec_i.dst + exec_i.src + {7'h00, cin}))
    else $error("add write back or decimal flag wrong");

  AST_PAIR: assert property (ce_i && exec_i.valid && exec_i.amode == ccfd_pkg::AM_PAIR_WORK &&
    exec_i.pair_addr[7:4] != ccfd_pkg::WORK_NIB |=> !result_o.pair_ok && prej_q)
    else $error("full pair accepted in working-only mode");

  AST_FX_SET: assert property (ce_i && exec_i.valid && !is_arith && !wr_flags &&
    exec_i.fx[ccfd_pkg::F_Z] == ccfd_pkg::FX_SET |=> flag_q[ccfd_pkg::F_Z])
    else $error("set class did not set flag");

  AST_SW_COND: assert property (s_acc(ccfd_pkg::IDX_CSTAT, 1'b0) |=>
    wb_dat_o[ccfd_pkg::ST_COND] == $past(cond_eval(csel_q, flag_q)))
    else $error("software condition status wrong");

endmodule : ccfd_top

// File: ccfd_top_tb.sv
`timescale 1ns/1ns
module ccfd_top_tb;
  // Clock, reset and enable
  logic                      clk_i    = 1'b0;
  logic                      rst_i    = 1'b1;
  logic                      ce_i     = 1'b1;
  // Bus master side
  logic                      wb_cyc_i = 1'b0;
  logic                      wb_stb_i = 1'b0;
  logic                      wb_we_i  = 1'b0;
  logic [9:2]                wb_adr_i = 8'h00;
  logic [3:0]                wb_sel_i = 4'hf;
  logic [31:0]               wb_dat_i = 32'h00000000;
  logic [31:0]               wb_dat_o;
  logic                      wb_ack_o;
  // Core step side; e is staged, ex is what the block sees
  ccfd_pkg::ccfd_exec_type   ex       = '0;
  ccfd_pkg::ccfd_exec_type   e        = '0;
  ccfd_pkg::ccfd_result_type result_o;
  logic [7:0]                imask_o;
  logic [7:0]                wbp_o;
  logic [5:0]                flags_o;
  // Score keeping
  int                        err_total  = 0;
  int                        n_compared = 0;
  logic [7:0]                rd;

  ccfd_top i_ccfd_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .exec_i(ex),
    .result_o(result_o), .imask_o(imask_o), .wbp_o(wbp_o), .flags_o(flags_o));

  // Free running 125 MHz clock
  always #4 clk_i = ~clk_i;

  // Byte compare, four-state so an unknown never matches
  task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_byte

  // Single bit compare
  task automatic chk_bit(input string name, input logic exp, input logic got);
    chk_byte(name, {7'h00, exp}, {7'h00, got});
  endtask : chk_bit

  // One classic cycle; waits for ack under a bound, no fixed latency assumed
  task automatic wb_xfer(input logic we, input logic [9:2] idx, input logic [7:0] wd,
                         output logic [7:0] rdv);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_sel_i <= 4'hf;
    wb_adr_i <= idx;
    wb_dat_i <= {24'h000000, wd};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 100);
    if (n >= 100) chk_bit("wb_ack_o", 1'b1, wb_ack_o);
    rdv = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb_xfer

  // Register write and checked read
  task automatic wr(input logic [9:2] idx, input logic [7:0] v);
    wb_xfer(1'b1, idx, v, rd);
  endtask : wr
  task automatic rdchk(input string name, input logic [9:2] idx, input logic [7:0] exp);
    wb_xfer(1'b0, idx, 8'h00, rd);
    chk_byte(name, exp, rd);
  endtask : rdchk

  // Present staged step for one edge; answer is settled 1 ns after it
  task automatic step;
    @(posedge clk_i);
    ex <= e;
    @(posedge clk_i);
    ex.valid <= 1'b0;
    #1;
  endtask : step

  // Reference condition table, flags ordered C Z S V D H
  function automatic logic cond_ref(input logic [3:0] cc, input logic [5:0] f);
    logic c, z, s, v;
    {c, z, s, v} = f[5:2];
    case (cc)
      4'h0: return 1'b0;
      4'h1: return s ^ v;
      4'h2: return z | (s ^ v);
      4'h3: return c | z;
      4'h4: return v;
      4'h5: return s;
      4'h6: return z;
      4'h7: return c;
      4'h8: return 1'b1;
      4'h9: return !(s ^ v);
      4'ha: return !(z | (s ^ v));
      4'hb: return !c && !z;
      4'hc: return !v;
      4'hd: return !s;
      4'he: return !z;
      default: return !c;
    endcase
  endfunction : cond_ref

  // Reset values, read-write and the unmapped hole
  task automatic t_regs;
    rdchk("interrupt_mask rst", 8'hfb, 8'h00);
    rdchk("status_flags rst", 8'hfc, 8'h00);
    rdchk("bank_pointer rst", 8'hfd, 8'h00);
    wr(8'hfb, 8'ha5);
    wr(8'hfd, 8'h5a);
    wr(8'hfc, 8'hff);
    wr(8'h80, 8'h33);
    rdchk("interrupt_mask", 8'hfb, 8'ha5);
    rdchk("bank_pointer", 8'hfd, 8'h5a);
    rdchk("status_flags", 8'hfc, 8'hfc);
    rdchk("unmapped", 8'h80, 8'h00);
    chk_byte("imask_o", 8'ha5, imask_o);
    chk_byte("wbp_o", 8'h5a, wbp_o);
    chk_byte("flags_o", 8'h3f, {2'b00, flags_o});
  endtask : t_regs

  // Every code against every C Z S V mix; flags kept so they stay current
  task automatic t_cond;
    e = '0;
    e.valid = 1'b1;
    e.opcode = 8'h50;
    for (int i = 0; i < 6; i++) e.fx[i] = ccfd_pkg::FX_KEEP;
    for (int p = 0; p < 16; p++) begin
      wr(8'hfc, {p[3:0], 4'h0});
      for (int c = 0; c < 16; c++) begin
        e.cc = c[3:0];
        step();
        chk_bit("cond_met", cond_ref(c[3:0], {p[3:0], 2'b00}), result_o.cond_met);
      end
    end
  endtask : t_cond

  // Add and add-with-carry: sum written back, D cleared, adder flags
  task automatic t_add;
    e.cc = 4'h0;
    wr(8'hfc, 8'h88);
    e.opcode = 8'h02;
    e.dst = 8'h7f;
    e.src = 8'h01;
    step();
    chk_byte("add data", 8'h80, result_o.data);
    chk_bit("add wr_dst", 1'b1, result_o.wr_dst);
    chk_byte("add flags", 8'h0d, {2'b00, flags_o});
    wr(8'hfc, 8'h88);
    e.opcode = 8'h12;
    e.dst = 8'hff;
    e.src = 8'h00;
    step();
    chk_byte("adc data", 8'h00, result_o.data);
    chk_bit("adc wr_dst", 1'b1, result_o.wr_dst);
    chk_byte("adc flags", 8'h31, {2'b00, flags_o});
  endtask : t_add

  // Five effect classes in one step; the undefined flag is not judged
  task automatic t_fx;
    wr(8'hfc, 8'h98);
    e.opcode = 8'h50;
    e.fx[5] = ccfd_pkg::FX_CLEAR;
    e.fx[4] = ccfd_pkg::FX_SET;
    e.fx[3] = ccfd_pkg::FX_CALC;
    e.fx[2] = ccfd_pkg::FX_KEEP;
    e.fx[1] = ccfd_pkg::FX_UNDEF;
    e.fx[0] = ccfd_pkg::FX_CALC;
    e.calc = 6'h09;
    step();
    chk_byte("fx flags a", 8'h1d, {2'b00, flags_o & 6'h3d});
    chk_bit("fx wr_dst", 1'b0, result_o.wr_dst);
    e.calc = 6'h00;
    step();
    chk_byte("fx flags b", 8'h14, {2'b00, flags_o & 6'h3d});
  endtask : t_fx

  // Pair modes: working-only refuses a full pair, the other takes a full pair
  task automatic t_pair;
    e.amode = ccfd_pkg::AM_PAIR_WORK;
    e.pair_addr = 8'h10;
    step();
    chk_bit("work full pair", 1'b0, result_o.pair_ok);
    e.pair_addr = 8'he4;
    step();
    chk_bit("work work pair", 1'b1, result_o.pair_ok);
    e.amode = ccfd_pkg::AM_PAIR_ANY;
    e.pair_addr = 8'h10;
    step();
    chk_bit("any full pair", 1'b1, result_o.pair_ok);
  endtask : t_pair

  // Own status and select registers: sticky reject, then the selected condition
  task automatic t_stat;
    rdchk("reject sticky", 8'h01, 8'h02);
    wr(8'h01, 8'h02);
    rdchk("reject cleared", 8'h01, 8'h00);
    wr(8'h00, 8'h08);
    rdchk("cond select", 8'h00, 8'h08);
    rdchk("select always", 8'h01, 8'h01);
    wr(8'hfc, 8'h80);
    wr(8'h00, 8'h07);
    rdchk("select carry", 8'h01, 8'h01);
    wr(8'h00, 8'h0f);
    rdchk("select no carry", 8'h01, 8'h00);
  endtask : t_stat

  // Enable low: a step that would clear carry must leave the flags alone
  task automatic t_hold;
    wr(8'hfc, 8'h80);
    @(posedge clk_i);
    ce_i <= 1'b0;
    ex   <= e;
    repeat (3) @(posedge clk_i);
    ex.valid <= 1'b0;
    ce_i     <= 1'b1;
    #1;
    chk_byte("held flags", 8'h20, {2'b00, flags_o});
  endtask : t_hold

  // Counts and verdict, the single end of the run
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  // Main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_cond();
    t_add();
    t_fx();
    t_pair();
    t_stat();
    t_hold();
    summarize();
  end

  // Watchdog: the run needs under a thousand cycles, allow far more
  initial begin
    #(8 * 20000);
    err_total++;
    summarize();
  end
endmodule : ccfd_top_tb
